//--- bench/nv_store_model.sv
// Nonvolatile clean-completion store seen by the command block
`timescale 1ns/1ps
module nv_store_model
(
  // Clock
  input  wire logic pclk,
  // Store port
  input  wire logic nv_clean_wr,
  input  wire logic nv_clean_val,
  output logic      nv_clean_pin
);
  // =====================================================
  // Storage cell
  logic stored_ff;

  // kept across resets
  // No reset input: the cell must outlive every power-on reset
  initial stored_ff = 1'h0;
  always @(posedge pclk)
  begin
    if (nv_clean_wr === 1'h1)
      stored_ff <= nv_clean_val;
  end
  assign nv_clean_pin = stored_ff;
endmodule

//--- bench/sanitize_key_scramble_cmd_bench.sv
// Self-checking bench for the key-scramble sanitize command block
`timescale 1ns/1ps
`include "sanitize_map.svh"
module sanitize_key_scramble_cmd_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hw_reset;
  logic        key_fault;
  logic        key_replace;
  logic        nv_clean_pin;
  logic        nv_clean_wr;
  logic        nv_clean_val;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  c;
  logic [15:0] f;
  logic [31:0] s;
  logic [15:0] p0;
  int          miscompares;
  int          n_checks;
  int          n_keys;
  int          k;

  key_scramble_ctl u_key_scramble_ctl
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_reset(hw_reset), .key_fault(key_fault), .key_replace(key_replace),
    .nv_clean_pin(nv_clean_pin), .nv_clean_wr(nv_clean_wr), .nv_clean_val(nv_clean_val)
  );
  nv_store_model u_nv_store_model
  (
    .pclk(pclk), .nv_clean_wr(nv_clean_wr), .nv_clean_val(nv_clean_val),
    .nv_clean_pin(nv_clean_pin)
  );

  // =====================================================
  // Clock, key-load counter, watchdog
  initial
  begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (key_replace === 1'h1)
      n_keys <= n_keys + 1;
  end
  initial
  begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  // =====================================================
  // Helpers
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    chk("pready", 32'h0000_0001, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // Poll while the masked read still equals v
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'h0, a, 32'h0000_0000);
      n++;
    end
    while ((rd & m) === v && n < 200);
  endtask

  task automatic issue(input logic [7:0] cd, input logic [15:0] ft, input logic [15:0] cn,
                       input logic [31:0] sg);
    apb(1'h1, `OFF_CMD, {24'h0, cd});
    apb(1'h1, `OFF_FEAT, {16'h0, ft});
    apb(1'h1, `OFF_COUNT, {16'h0, cn});
    apb(1'h1, `OFF_LBA_LO, sg);
    apb(1'h1, `OFF_GO, 32'h0000_0001);
    poll(`OFF_RSTAT, 32'h0008_0000, 32'h0008_0000);
  endtask

  task automatic expect_out(input logic e, input logic [2:0] st, input logic [15:0] cn,
                            input logic [15:0] lb);
    apb(1'h0, `OFF_RSTAT, 32'h0000_0000);
    chk("state", {29'h0, st}, {29'h0, rd[18:16]});
    chk("status_err", {31'h0, e}, {31'h0, rd[`STAT_ERR_BIT]});
    chk("abort", {31'h0, e}, {31'h0, rd[8+`ERR_ABORT_BIT]});
    apb(1'h0, `OFF_RCOUNT, 32'h0000_0000);
    chk("count_out", {16'h0, cn}, rd);
    apb(1'h0, `OFF_RLBA, 32'h0000_0000);
    chk("lba_out", {16'h0, lb}, rd);
  endtask

  function automatic logic [15:0] ncnt(input logic cl, input logic ru, input logic fz,
                                       input logic af);
    return {cl, ru, fz, af, 12'h000};
  endfunction

  function automatic logic [15:0] rsn(input logic [7:0] cd, input logic [15:0] ft);
    if (cd !== `CMD_SANITIZE)
      return 16'h0000;
    if (ft !== `FEAT_SCRAMBLE)
      return {8'h00, `RSN_FEATURE};
    return 16'h0000;
  endfunction

  task automatic rst;
    presetn <= 1'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    repeat (6) @(posedge pclk);
  endtask

  task automatic erase(input logic flt, input logic [15:0] cn);
    key_fault <= flt;
    issue(`CMD_SANITIZE, `FEAT_SCRAMBLE, cn, `SCRAMBLE_SIG);
    poll(`OFF_RSTAT, 32'h0007_0000, 32'h0002_0000);
    key_fault <= 1'h0;
  endtask

  // =====================================================
  // Scenarios
  initial
  begin
    presetn   = 1'h0;
    psel      = 1'h0;
    penable   = 1'h0;
    pwrite    = 1'h0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    hw_reset  = 1'h0;
    key_fault = 1'h0;
    void'($urandom(63));
    rst();
    expect_out(1'h0, sanitize_pkg::erase_idle_state, 16'h0000, `PROG_IDLE);
    apb(1'h0, 12'h0FC, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0, er});
    apb(1'h0, `OFF_CTRL, 32'h0000_0000);
    chk("ctrl_reset", 32'h0000_0003, rd);
    // Bad code, bad feature, bad signature
    for (k = 0; k < 6; k++)
    begin
      c = (k < 2) ? (8'($urandom) | 8'h01) : `CMD_SANITIZE;
      f = (k < 2 || k > 3) ? `FEAT_SCRAMBLE : (16'($urandom) | 16'h0100);
      s = (k > 3) ? (`SCRAMBLE_SIG ^ (32'($urandom) | 32'h0000_0001)) : `SCRAMBLE_SIG;
      issue(c, f, 16'h0000, s);
      expect_out(1'h1, sanitize_pkg::erase_idle_state, 16'h0000, rsn(c, f));
    end
    // Not supported, then not the encrypting variant
    for (k = 0; k < 2; k++)
    begin
      apb(1'h1, `OFF_CTRL, (k == 0) ? 32'h0000_0002 : 32'h0000_0001);
      issue(`CMD_SANITIZE, `FEAT_SCRAMBLE, 16'h0000, `SCRAMBLE_SIG);
      expect_out(1'h1, sanitize_pkg::erase_idle_state, 16'h0000, 16'h0002);
    end
    apb(1'h1, `OFF_CTRL, 32'h0000_0003);
    // Clean erase with a check while running
    k = n_keys;
    issue(`CMD_SANITIZE, `FEAT_SCRAMBLE, 16'h0000, `SCRAMBLE_SIG);
    chk("key_load", 32'(k + 1), 32'(n_keys));
    apb(1'h0, `OFF_RCOUNT, 32'h0000_0000);
    chk("running_bit", {16'h0, ncnt(1'h0, 1'h1, 1'h0, 1'h0)}, rd);
    apb(1'h0, `OFF_RLBA, 32'h0000_0000);
    p0 = rd[15:0];
    apb(1'h0, `OFF_RLBA, 32'h0000_0000);
    chk("progress_rise", 32'h0000_0001, {31'h0, rd[15:0] > p0 && rd[31:16] == 16'h0});
    issue(`CMD_SANITIZE, `FEAT_SCRAMBLE, 16'h0000, `SCRAMBLE_SIG);
    expect_out(1'h1, sanitize_pkg::erase_running_state, 16'h0000, 16'h0000);
    poll(`OFF_RSTAT, 32'h0007_0000, 32'h0002_0000);
    // The refused request's error stands until the next command
    issue(`CMD_SANITIZE, `FEAT_STATUS, 16'h0000, `SCRAMBLE_SIG);
    expect_out(1'h0, sanitize_pkg::erase_succeeded_state, 16'h8000, `PROG_IDLE);
    rst();
    expect_out(1'h0, sanitize_pkg::erase_succeeded_state, 16'h8000, `PROG_IDLE);
    // Failure with policy one, left by a status query
    erase(1'h1, 16'h0010);
    expect_out(1'h0, sanitize_pkg::erase_failed_state, 16'h0000, `PROG_IDLE);
    issue(`CMD_SANITIZE, `FEAT_STATUS, 16'h0000, `SCRAMBLE_SIG);
    expect_out(1'h0, sanitize_pkg::erase_idle_state, 16'h0000, `PROG_IDLE);
    // Failure with policy zero refuses policy one
    erase(1'h1, 16'h0000);
    issue(`CMD_SANITIZE, `FEAT_SCRAMBLE, 16'h0010, `SCRAMBLE_SIG);
    expect_out(1'h1, sanitize_pkg::erase_failed_state, 16'h0000, 16'h0001);
    // Freeze lock, hardware reset, power-on reset
    apb(1'h1, `OFF_CTRL, 32'h0000_000B);
    poll(`OFF_CTRL, 32'h0000_0008, 32'h0000_0008);
    expect_out(1'h0, sanitize_pkg::erase_frozen_state, 16'h2000, `PROG_IDLE);
    issue(`CMD_SANITIZE, `FEAT_SCRAMBLE, 16'h0000, `SCRAMBLE_SIG);
    expect_out(1'h1, sanitize_pkg::erase_frozen_state, 16'h0000, 16'h0003);
    hw_reset <= 1'h1;
    @(posedge pclk);
    hw_reset <= 1'h0;
    apb(1'h0, `OFF_RSTAT, 32'h0000_0000);
    chk("hw_reset_idle", 32'h0000_0000, {29'h0, rd[18:16]});
    issue(`CMD_SANITIZE, `FEAT_SCRAMBLE, 16'h0000, `SCRAMBLE_SIG);
    expect_out(1'h1, sanitize_pkg::erase_idle_state, 16'h0000, 16'h0003);
    rst();
    // Freeze refused under antifreeze, then antifreeze reported
    apb(1'h1, `OFF_CTRL, 32'h0000_000F);
    poll(`OFF_CTRL, 32'h0000_0008, 32'h0000_0008);
    expect_out(1'h1, sanitize_pkg::erase_idle_state, 16'h0000, 16'h0004);
    issue(`CMD_SANITIZE, `FEAT_STATUS, 16'h0000, `SCRAMBLE_SIG);
    expect_out(1'h0, sanitize_pkg::erase_idle_state, 16'h1000, `PROG_IDLE);
    print_verdict();
  end
endmodule

//--- include/sanitize_map.svh
// Register offsets, field positions, codes and counts of the key-scramble block
`ifndef SANITIZE_MAP_SVH
`define SANITIZE_MAP_SVH

// =====================================================
// Register offsets (byte addresses)
`define OFF_CMD        12'h000
`define OFF_FEAT       12'h004
`define OFF_COUNT      12'h008
`define OFF_LBA_LO     12'h00C
`define OFF_LBA_HI     12'h010
`define OFF_GO         12'h014
`define OFF_CTRL       12'h018
`define OFF_RSTAT      12'h01C
`define OFF_RCOUNT     12'h020
`define OFF_RLBA       12'h024

// =====================================================
// Register fields
`define GO_BIT         0
`define CTRL_SUPPORT   0
`define CTRL_ENCRYPT   1
`define CTRL_ANTIFRZ   2
`define CTRL_FREEZE    3
`define CTRL_RST       3'h3

// =====================================================
// Command decode
`define CMD_SANITIZE   8'hB4
`define FEAT_SCRAMBLE  16'h0011
`define FEAT_STATUS    16'h0000
`define SCRAMBLE_SIG   32'h4372_7970
`define POLICY_BIT     4

// =====================================================
// Output fields
`define CNT_CLEAN      15
`define CNT_RUNNING    14
`define CNT_FROZEN     13
`define CNT_ANTIFRZ    12
`define ERR_ABORT_BIT  2
`define STAT_ERR_BIT   0
`define RSN_NONE       8'h00
`define RSN_INCOMPLETE 8'h01
`define RSN_FEATURE    8'h02
`define RSN_FROZEN     8'h03
`define RSN_ANTIFRZ    8'h04

// =====================================================
// Progress and timing
`define PROG_IDLE      16'hFFFF
`define PROG_STEP      16'h0100
`define PROG_LAST      16'hFF00
`define STRAP_WAIT     2'h2

`endif

//--- include/sanitize_pkg.sv
// Types shared by the key-scramble command block
package sanitize_pkg;

  // Sanitize state machine
  typedef enum logic [2:0]
  {
    erase_idle_state,
    erase_frozen_state,
    erase_running_state,
    erase_failed_state,
    erase_succeeded_state
  } erase_state_t;

  // Command fields as written by the host
  typedef struct packed
  {
    logic [7:0]  code;
    logic [15:0] feature;
    logic [15:0] count;
    logic [47:0] lba;
  } ata_cmd_t;

  // Outcome of the last completion
  typedef struct packed
  {
    logic       err;
    logic [7:0] reason;
  } ata_result_t;

endpackage

//--- logic/key_erase_engine.sv
// Key-change erase engine with a 16-bit progress numerator
`timescale 1ns/1ps
`include "sanitize_map.svh"
module key_erase_engine
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        start,
  input  wire logic        fault,
  // Progress and result
  output logic [15:0]      progress,
  output logic             done,
  output logic             ok,
  output logic             key_replace
);

  logic        run_ff;
  logic [15:0] prog_ff;
  logic        fault_ff;
  logic        done_ff;
  logic        key_ff;

  // =====================================================
  // Progress walk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_ff  <= 1'b0;
      prog_ff <= 16'h0000;
    end
    else if (start)
    begin
      run_ff  <= 1'b1;
      prog_ff <= 16'h0000;
    end
    else if (run_ff && prog_ff == `PROG_LAST)
      run_ff <= 1'b0;
    else if (run_ff)
      prog_ff <= prog_ff + `PROG_STEP;
  end

  // Any fault during the walk spoils the result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_ff <= 1'b0;
    else if (start)
      fault_ff <= 1'b0;
    else if (run_ff && fault)
      fault_ff <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_ff <= 1'b0;
      key_ff  <= 1'b0;
    end
    else
    begin
      done_ff <= run_ff && prog_ff == `PROG_LAST && !start;
      key_ff  <= start;
    end
  end

  assign progress    = prog_ff;
  assign done        = done_ff;
  assign ok          = !fault_ff;
  assign key_replace = key_ff;

endmodule

//--- logic/key_scramble_ctl.sv
// Key-scramble sanitize command interpreter behind an APB register file
//
// Contract
// [R01] Command B4h with feature 0011h selects the key-scramble erase.
// [R02] Address bits 31:0 must hold 4372_7970h before acceptance.
// [R03] Policy bit one lets a status query leave the failed state.
// [R04] Accept only when supported and idle, failed or succeeded.
// [R05] Acceptance starts an erase that replaces the data keys.
// [R06] Failed with policy zero aborts requests with policy one.
// [R07] Count bit 15 returns the stored clean-completion value.
// [R08] Count bit 14 is one exactly while in progress.
// [R09] Count bit 13 is one exactly while frozen.
// [R10] Count bit 12 returns antifreeze; bits 11:0 read zero.
// [R11] While in progress, address bits 15:0 give progress over 65536.
// [R12] With no erase running the progress field reads FFFFh.
// [R13] Clean value one means succeeded; zero means in progress. The code enters failed when an erase ends with zero.
// [R14] Clean-completion value is kept across power-on resets.
// [R15] Abort once a freeze-lock has completed since power-on.
// [R16] Failed, earlier policy zero, new policy one: abort.
// [R17] Error reason codes 00h to 04h in address bits 7:0.
// [R18] Only the encrypting variant accepts the subcommand.
// [R19] Every abort sets the error bit and loads a reason.
// [R20] Frozen returns to idle on power-on or hardware reset. After power-on the code restores succeeded if the stored clean value is one.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "sanitize_map.svh"
module key_scramble_ctl
(
  // Clock and power-on reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Drive controller
  input  wire logic        hw_reset,
  input  wire logic        key_fault,
  output logic             key_replace,
  // Nonvolatile clean-completion store
  input  wire logic        nv_clean_pin,
  output logic             nv_clean_wr,
  output logic             nv_clean_val
);

  sanitize_pkg::erase_state_t state_ff;
  sanitize_pkg::erase_state_t nxt_state;
  sanitize_pkg::ata_cmd_t     cmd_ff;
  sanitize_pkg::ata_result_t  res_ff;
  sanitize_pkg::ata_result_t  nxt_res;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_data;
  logic [2:0]  ctrl_ff;
  logic        go_ff;
  logic        frz_ff;
  logic        clean_ff;
  logic        nxt_clean;
  logic        policy_ff;
  logic        nxt_policy;
  logic        lock_ff;
  logic        nxt_lock;
  logic        res_load;
  logic        start;
  logic        nv_meta_ff;
  logic        nv_sync_ff;
  logic [1:0]  strap_cnt_ff;
  logic        strap_done_ff;
  logic        nv_wr_ff;
  logic        nv_val_ff;
  logic        go_take;
  logic        frz_take;
  logic        apb_wr;
  logic        rd_load;
  logic        req_policy;
  logic        run_now;
  logic [15:0] eng_prog;
  logic        eng_done;
  logic        eng_ok;
  logic [15:0] cnt_word;
  logic [7:0]  err_byte;
  logic [7:0]  stat_byte;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // =====================================================
  // APB handshake: one wait state on every access
  assign apb_wr  = psel && penable && pready_ff && pwrite;
  assign rd_load = psel && penable && !pready_ff;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = a == `OFF_CMD || a == `OFF_FEAT || a == `OFF_COUNT
            || a == `OFF_LBA_LO || a == `OFF_LBA_HI || a == `OFF_GO
            || a == `OFF_CTRL || a == `OFF_RSTAT || a == `OFF_RCOUNT
            || a == `OFF_RLBA;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= rd_load;
      if (rd_load)
      begin
        pslverr_ff <= !addr_hit(paddr);
        prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
      end
      else
        pslverr_ff <= 1'b0;
    end
  end

  // =====================================================
  // Command field registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_ff  <= '0;
      ctrl_ff <= `CTRL_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == `OFF_CMD)
        cmd_ff.code <= pwdata[7:0];
      else if (paddr == `OFF_FEAT)
        cmd_ff.feature <= pwdata[15:0];
      else if (paddr == `OFF_COUNT)
        cmd_ff.count <= pwdata[15:0];
      else if (paddr == `OFF_LBA_LO)
        cmd_ff.lba[31:0] <= pwdata;
      else if (paddr == `OFF_LBA_HI)
        cmd_ff.lba[47:32] <= pwdata[15:0];
      else if (paddr == `OFF_CTRL)
        ctrl_ff <= pwdata[2:0];
    end
  end

  // Issue strobes stay pending until taken; a new write wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      go_ff  <= 1'b0;
      frz_ff <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr == `OFF_GO && pwdata[`GO_BIT])
        go_ff <= 1'b1;
      else if (go_take)
        go_ff <= 1'b0;
      if (apb_wr && paddr == `OFF_CTRL && pwdata[`CTRL_FREEZE])
        frz_ff <= 1'b1;
      else if (frz_take)
        frz_ff <= 1'b0;
    end
  end

  // =====================================================
  // Clean-completion value from the nonvolatile store
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_meta_ff <= 1'b0;
      nv_sync_ff <= 1'b0;
    end
    else
    begin
      nv_meta_ff <= nv_clean_pin;
      nv_sync_ff <= nv_meta_ff;
    end
  end

  // Wait for the synchroniser to settle before taking the stored value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_cnt_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      strap_cnt_ff  <= strap_cnt_ff + 2'h1;
      strap_done_ff <= strap_cnt_ff == `STRAP_WAIT;
    end
  end

  // =====================================================
  // Sanitize state machine and command decode
  assign frz_take   = frz_ff && strap_done_ff && !hw_reset && !eng_done;
  assign go_take    = go_ff && strap_done_ff && !hw_reset && !eng_done && !frz_take;
  assign req_policy = cmd_ff.count[`POLICY_BIT];

  always_comb
  begin
    nxt_state  = state_ff;
    nxt_clean  = clean_ff;
    nxt_policy = policy_ff;
    nxt_lock   = lock_ff;
    nxt_res    = res_ff;
    res_load   = 1'b0;
    start      = 1'b0;
    if (!strap_done_ff)
    begin
      if (strap_cnt_ff == `STRAP_WAIT)
      begin
        // [R14] restore clean value
        nxt_clean = nv_sync_ff;
        nxt_state = nv_sync_ff ? sanitize_pkg::erase_succeeded_state
                               : sanitize_pkg::erase_idle_state;
      end
    end
    // Only frozen yields to reset, so a coinciding erase completion is not lost
    else if (hw_reset && state_ff == sanitize_pkg::erase_frozen_state)
    begin
      // [R20] frozen leaves on reset
      nxt_state = sanitize_pkg::erase_idle_state;
    end
    else if (eng_done)
    begin
      // [R13] state follows clean value
      nxt_clean = eng_ok;
      nxt_state = eng_ok ? sanitize_pkg::erase_succeeded_state
                         : sanitize_pkg::erase_failed_state;
    end
    else if (frz_take)
    begin
      res_load = 1'b1;
      nxt_res  = '{err: 1'b0, reason: `RSN_NONE};
      // [R17] antifreeze blocks lock
      if (ctrl_ff[`CTRL_ANTIFRZ])
        nxt_res = '{err: 1'b1, reason: `RSN_ANTIFRZ};
      else if (state_ff == sanitize_pkg::erase_running_state)
        nxt_res = '{err: 1'b1, reason: `RSN_NONE};
      else
      begin
        nxt_state = sanitize_pkg::erase_frozen_state;
        nxt_lock  = 1'b1;
      end
    end
    else if (go_take)
    begin
      res_load = 1'b1;
      // [R19] abort carries a reason
      nxt_res  = '{err: 1'b1, reason: `RSN_NONE};
      if (cmd_ff.code != `CMD_SANITIZE)
        nxt_res = '{err: 1'b1, reason: `RSN_NONE};
      else if (cmd_ff.feature == `FEAT_STATUS)
      begin
        nxt_res = '{err: 1'b0, reason: `RSN_NONE};
        // [R03] policy one frees failed
        if (state_ff == sanitize_pkg::erase_failed_state && policy_ff)
          nxt_state = sanitize_pkg::erase_idle_state;
      end
      // [R01] [R18] feature and variant
      else if (cmd_ff.feature != `FEAT_SCRAMBLE || !ctrl_ff[`CTRL_SUPPORT]
               || !ctrl_ff[`CTRL_ENCRYPT])
        nxt_res = '{err: 1'b1, reason: `RSN_FEATURE};
      // [R15] freeze-lock since power-on
      else if (lock_ff || state_ff == sanitize_pkg::erase_frozen_state)
        nxt_res = '{err: 1'b1, reason: `RSN_FROZEN};
      // [R02] signature check
      else if (cmd_ff.lba[31:0] != `SCRAMBLE_SIG)
        nxt_res = '{err: 1'b1, reason: `RSN_NONE};
      // [R04] allowed start states
      else if (state_ff == sanitize_pkg::erase_running_state)
        nxt_res = '{err: 1'b1, reason: `RSN_NONE};
      // [R06] [R16] failed policy lock
      else if (state_ff == sanitize_pkg::erase_failed_state && !policy_ff && req_policy)
        nxt_res = '{err: 1'b1, reason: `RSN_INCOMPLETE};
      else
      begin
        // [R05] [R13] start key change
        nxt_res    = '{err: 1'b0, reason: `RSN_NONE};
        start      = 1'b1;
        nxt_state  = sanitize_pkg::erase_running_state;
        nxt_policy = req_policy;
        nxt_clean  = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff  <= sanitize_pkg::erase_idle_state;
      clean_ff  <= 1'b0;
      policy_ff <= 1'b0;
      lock_ff   <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      clean_ff  <= nxt_clean;
      policy_ff <= nxt_policy;
      lock_ff   <= nxt_lock;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      res_ff <= '{err: 1'b0, reason: `RSN_NONE};
    else if (res_load)
      res_ff <= nxt_res;
  end

  // Write-back pulse keeps the store in step with every change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_wr_ff  <= 1'b0;
      nv_val_ff <= 1'b0;
    end
    else
    begin
      nv_wr_ff  <= strap_done_ff && nxt_clean != clean_ff;
      nv_val_ff <= nxt_clean;
    end
  end

  key_erase_engine u_engine
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (start),
    .fault       (key_fault),
    .progress    (eng_prog),
    .done        (eng_done),
    .ok          (eng_ok),
    .key_replace (key_replace)
  );

  // =====================================================
  // Read data
  assign run_now = state_ff == sanitize_pkg::erase_running_state;

  always_comb
  begin
    cnt_word  = 16'h0000;
    err_byte  = 8'h00;
    stat_byte = 8'h00;
    // [R07] [R08] [R09] [R10] normal count
    cnt_word[`CNT_CLEAN]   = clean_ff;
    cnt_word[`CNT_RUNNING] = run_now;
    cnt_word[`CNT_FROZEN]  = state_ff == sanitize_pkg::erase_frozen_state;
    cnt_word[`CNT_ANTIFRZ] = ctrl_ff[`CTRL_ANTIFRZ];
    err_byte[`ERR_ABORT_BIT] = res_ff.err;
    stat_byte[`STAT_ERR_BIT] = res_ff.err;
    rd_data = 32'h0000_0000;
    if (paddr == `OFF_CMD)
      rd_data = {24'h00_0000, cmd_ff.code};
    else if (paddr == `OFF_FEAT)
      rd_data = {16'h0000, cmd_ff.feature};
    else if (paddr == `OFF_COUNT)
      rd_data = {16'h0000, cmd_ff.count};
    else if (paddr == `OFF_LBA_LO)
      rd_data = cmd_ff.lba[31:0];
    else if (paddr == `OFF_LBA_HI)
      rd_data = {16'h0000, cmd_ff.lba[47:32]};
    else if (paddr == `OFF_GO)
      rd_data = {31'h0000_0000, go_ff};
    else if (paddr == `OFF_CTRL)
      rd_data = {28'h000_0000, frz_ff, ctrl_ff};
    else if (paddr == `OFF_RSTAT)
      rd_data = {12'h000, go_ff, state_ff, err_byte, stat_byte};
    else if (paddr == `OFF_RCOUNT)
      rd_data = res_ff.err ? 32'h0000_0000 : {16'h0000, cnt_word};
    else if (paddr == `OFF_RLBA)
    begin
      // [R11] [R12] [R17] progress or reason
      if (res_ff.err)
        rd_data = {24'h00_0000, res_ff.reason};
      else
        rd_data = {16'h0000, run_now ? eng_prog : `PROG_IDLE};
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign nv_clean_wr  = nv_wr_ff;
  assign nv_clean_val = nv_val_ff;

  // =====================================================
  // Checks
  start_decode_a: assert property (start |-> cmd_ff.code == `CMD_SANITIZE // [R01]
    && cmd_ff.feature == `FEAT_SCRAMBLE && ctrl_ff[`CTRL_ENCRYPT])
    else $error("erase started without key-scramble decode");

  sig_check_a: assert property (start |-> cmd_ff.lba[31:0] == `SCRAMBLE_SIG) // [R02]
    else $error("erase started with a bad signature");

  status_exit_a: assert property (go_take && cmd_ff.code == `CMD_SANITIZE // [R03]
    && cmd_ff.feature == `FEAT_STATUS && policy_ff
    && state_ff == sanitize_pkg::erase_failed_state
    |=> state_ff == sanitize_pkg::erase_idle_state)
    else $error("status query did not leave failed state");

  key_change_a: assert property (start |-> !run_now ##1 key_replace && run_now) // [R05]
    else $error("acceptance did not replace keys");

  policy_lock_a: assert property (go_take && cmd_ff.feature == `FEAT_SCRAMBLE // [R06]
    && !lock_ff && state_ff == sanitize_pkg::erase_failed_state && !policy_ff
    && req_policy |=> res_ff.err && state_ff == sanitize_pkg::erase_failed_state)
    else $error("failed state accepted a policy-one request");

  run_flag_a: assert property (rd_load && !pwrite && paddr == `OFF_RCOUNT // [R08]
    && !res_ff.err |=> prdata[`CNT_RUNNING] == $past(run_now))
    else $error("running flag disagrees with state");

  idle_prog_a: assert property (rd_load && !pwrite && paddr == `OFF_RLBA // [R12]
    && !res_ff.err && !run_now |=> prdata[15:0] == `PROG_IDLE)
    else $error("idle progress not FFFFh");

  done_state_a: assert property (strap_done_ff && !hw_reset && eng_done // [R13]
    |=> clean_ff == $past(eng_ok) && (clean_ff
    == (state_ff == sanitize_pkg::erase_succeeded_state)))
    else $error("end state does not follow clean value");

  lock_abort_a: assert property (go_take && lock_ff && cmd_ff.code == `CMD_SANITIZE // [R15]
    && cmd_ff.feature == `FEAT_SCRAMBLE && ctrl_ff[`CTRL_SUPPORT]
    && ctrl_ff[`CTRL_ENCRYPT] |=> res_ff.err && res_ff.reason == `RSN_FROZEN)
    else $error("locked device did not abort with frozen reason");

  frozen_reset_a: assert property (strap_done_ff && hw_reset // [R20]
    && state_ff == sanitize_pkg::erase_frozen_state
    |=> state_ff == sanitize_pkg::erase_idle_state)
    else $error("hardware reset left device frozen");

endmodule
